/* File: design/mac_stats_defs.svh */
`ifndef MAC_STATS_DEFS_SVH
`define MAC_STATS_DEFS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define RX_BYTES_LOW_OFS          32'h0000_0200
`define RX_BYTES_HIGH_OFS         32'h0000_0204
`define TX_BYTES_LOW_OFS          32'h0000_0208
`define TX_BYTES_HIGH_OFS         32'h0000_020C
`define RX_UNDERSIZE_LOW_OFS      32'h0000_0210
`define RX_UNDERSIZE_HIGH_OFS     32'h0000_0214
`define RX_FRAGMENT_LOW_OFS       32'h0000_0218
`define RX_FRAGMENT_HIGH_OFS      32'h0000_021C
`define RX_LEN64_LOW_OFS          32'h0000_0220
`define RX_LEN64_HIGH_OFS         32'h0000_0224
`define RX_LEN65_127_LOW_OFS      32'h0000_0228
`define RX_LEN65_127_HIGH_OFS     32'h0000_022C
`define RX_LEN128_255_LOW_OFS     32'h0000_0230
`define RX_LEN128_255_HIGH_OFS    32'h0000_0234
`define RX_LEN256_511_LOW_OFS     32'h0000_0238
`define RX_LEN256_511_HIGH_OFS    32'h0000_023C
`define RX_LEN512_1023_LOW_OFS    32'h0000_0240
`define RX_LEN512_1023_HIGH_OFS   32'h0000_0244
`define RX_LEN1024_MAX_LOW_OFS    32'h0000_0248
`define RX_LEN1024_MAX_HIGH_OFS   32'h0000_024C
`define RX_OVERSIZE_LOW_OFS       32'h0000_0250
`define RX_OVERSIZE_HIGH_OFS      32'h0000_0254
`define TX_LEN64_LOW_OFS          32'h0000_0258
`define TX_LEN64_HIGH_OFS         32'h0000_025C

// Counter count and counter indices
`define NUM_COUNTERS              4'hC
`define IDX_RX_BYTES              4'h0
`define IDX_TX_BYTES              4'h1
`define IDX_RX_UNDERSIZE          4'h2
`define IDX_RX_FRAGMENT           4'h3
`define IDX_RX_LEN64              4'h4
`define IDX_RX_LEN65_127          4'h5
`define IDX_RX_LEN128_255         4'h6
`define IDX_RX_LEN256_511         4'h7
`define IDX_RX_LEN512_1023        4'h8
`define IDX_RX_LEN1024_MAX        4'h9
`define IDX_RX_OVERSIZE           4'hA
`define IDX_TX_LEN64              4'hB

// ----------------------------------------------------------------------
// Frame length limits
// ----------------------------------------------------------------------
`define LEN_64                    14'h0040
`define LEN_127                   14'h007F
`define LEN_255                   14'h00FF
`define LEN_511                   14'h01FF
`define LEN_1023                  14'h03FF
`define MAX_LEGAL_LEN_DEFAULT     14'h05EE

// ----------------------------------------------------------------------
// AXI response codes
// ----------------------------------------------------------------------
`define RESP_OKAY                 2'h0
`define RESP_SLVERR               2'h2
`define RESP_DECERR               2'h3

`endif

/* File: design/mac_stats_pkg.sv */
package mac_stats_pkg;

  // Receive flag vector layout, 30 bits
  typedef struct packed {
    logic [12:0] spare;      // Unused, bits 29:17
    logic [13:0] length;     // Frame length in bytes, DA to FCS
    logic        other_err;  // Malformed for a reason other than FCS
    logic        fcs_bad;    // Frame check sequence failed
    logic        good;       // Frame error-free
  } rx_flags_s;

  // Transmit flag vector layout, 26 bits
  typedef struct packed {
    logic [10:0] spare;      // Unused, bits 25:15
    logic [13:0] length;     // Frame length in bytes, DA to FCS
    logic        good;       // Frame error-free
  } tx_flags_s;

  // Read channel state
  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } rd_state_e;

endpackage

/* File: design/mac_frame_statistics_counters.sv */
`include "mac_stats_defs.svh"

module mac_frame_statistics_counters #(
  parameter logic [13:0] MAX_LEGAL_LEN = `MAX_LEGAL_LEN_DEFAULT,
  parameter int CNT_W = 64
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_reconfig,
  input  wire logic [25:0] i_tx_flags,
  input  wire logic        i_tx_flags_valid,
  input  wire logic [29:0] i_rx_flags,
  input  wire logic        i_rx_flags_valid,
  output logic      [25:0] o_tx_statistics_vector,
  output logic             o_tx_statistics_valid,
  output logic      [29:0] o_rx_statistics_vector,
  output logic             o_rx_statistics_valid,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------

  // True when an address falls inside the counter window
  function automatic logic in_window(input logic [31:0] addr);
    in_window = (addr >= `RX_BYTES_LOW_OFS) &&
                (addr <= `TX_LEN64_HIGH_OFS);
  endfunction

  // Counter index for an address inside the window
  function automatic logic [3:0] cnt_index(input logic [31:0] addr);
    logic [31:0] rel;
    rel = addr - `RX_BYTES_LOW_OFS;
    cnt_index = rel[6:3];
  endfunction

  // --------------------------------------------------------------------
  // Flag vector capture
  // --------------------------------------------------------------------
  mac_stats_pkg::rx_flags_s rx_reg; // Sampled receive flags
  mac_stats_pkg::tx_flags_s tx_reg; // Sampled transmit flags
  logic rx_vld_reg; // Receive strobe, delayed with flags
  logic tx_vld_reg; // Transmit strobe, delayed with flags

  // Register the vectors on their strobes; flags only move with a strobe
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_reg <= '0;
      tx_reg <= '0;
      rx_vld_reg <= 1'b0;
      tx_vld_reg <= 1'b0;
    end else begin
      rx_vld_reg <= i_rx_flags_valid;
      tx_vld_reg <= i_tx_flags_valid;
      if (i_rx_flags_valid) begin
        rx_reg <= i_rx_flags;
      end
      if (i_tx_flags_valid) begin
        tx_reg <= i_tx_flags;
      end
    end
  end

  // Vectors brought out for counting in outside logic
  assign o_rx_statistics_vector = rx_reg;
  assign o_rx_statistics_valid = rx_vld_reg;
  assign o_tx_statistics_vector = tx_reg;
  assign o_tx_statistics_valid = tx_vld_reg;

  // --------------------------------------------------------------------
  // Frame classification
  // --------------------------------------------------------------------
  logic rx_clean; // No FCS or other error
  logic [CNT_W-1:0] inc [`NUM_COUNTERS]; // Increment per counter

  always_comb begin
    rx_clean = !rx_reg.fcs_bad && !rx_reg.other_err;
    for (int k = 0; k < `NUM_COUNTERS; k++) begin
      inc[k] = '0;
    end
    // Byte counts, every frame
    if (rx_vld_reg) begin
      inc[`IDX_RX_BYTES] = CNT_W'(rx_reg.length);
    end
    if (tx_vld_reg) begin
      inc[`IDX_TX_BYTES] = CNT_W'(tx_reg.length);
    end
    // Receive length classes
    if (rx_vld_reg) begin
      if (rx_reg.length < `LEN_64) begin
        if (rx_clean) begin
          inc[`IDX_RX_UNDERSIZE] = CNT_W'(1);
        end
        if (rx_reg.fcs_bad) begin
          inc[`IDX_RX_FRAGMENT] = CNT_W'(1);
        end
      end else if (rx_reg.length > MAX_LEGAL_LEN) begin
        if (rx_clean) begin
          inc[`IDX_RX_OVERSIZE] = CNT_W'(1);
        end
      end else if (rx_reg.good && rx_clean) begin
        if (rx_reg.length == `LEN_64) begin
          inc[`IDX_RX_LEN64] = CNT_W'(1);
        end else if (rx_reg.length <= `LEN_127) begin
          inc[`IDX_RX_LEN65_127] = CNT_W'(1);
        end else if (rx_reg.length <= `LEN_255) begin
          inc[`IDX_RX_LEN128_255] = CNT_W'(1);
        end else if (rx_reg.length <= `LEN_511) begin
          inc[`IDX_RX_LEN256_511] = CNT_W'(1);
        end else if (rx_reg.length <= `LEN_1023) begin
          inc[`IDX_RX_LEN512_1023] = CNT_W'(1);
        end else begin
          inc[`IDX_RX_LEN1024_MAX] = CNT_W'(1);
        end
      end
    end
    // Transmit 64-byte frames
    if (tx_vld_reg && tx_reg.good && (tx_reg.length == `LEN_64)) begin
      inc[`IDX_TX_LEN64] = CNT_W'(1);
    end
  end

  // --------------------------------------------------------------------
  // Counter bank
  // --------------------------------------------------------------------
  logic [CNT_W-1:0] cnt_reg [`NUM_COUNTERS]; // Counter storage

  // No reset: counters wrap and clear only on reconfiguration
  genvar g;
  generate
    for (g = 0; g < `NUM_COUNTERS; g++) begin : g_cnt
      always_ff @(posedge i_core_clk) begin
        if (i_reconfig) begin
          cnt_reg[g] <= '0;
        end else begin
          cnt_reg[g] <= cnt_reg[g] + inc[g];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Write channel
  // --------------------------------------------------------------------
  logic wr_take; // Write address and data accepted
  logic rd_take; // Read address accepted

  // Reads take priority so transaction order is always defined
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
                   !rd_take;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;

  // Every write is refused; counter contents are never touched
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (wr_take) begin
      s_axi_bvalid <= 1'b1;
      if (in_window(s_axi_awaddr)) begin
        s_axi_bresp <= `RESP_SLVERR;
      end else begin
        s_axi_bresp <= `RESP_DECERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------
  mac_stats_pkg::rd_state_e rd_state_reg; // Read channel state
  logic last_low_reg; // Previous transaction read a low word
  logic [3:0] last_idx_reg; // Counter index of that low read
  logic [31:0] high_snap_reg; // High word taken with the low word
  logic [3:0] ar_idx; // Index of the requested counter
  logic ar_hit; // Requested address word-aligned and inside window
  logic ar_high; // Requested word is the high word

  assign s_axi_arready = (rd_state_reg == mac_stats_pkg::RD_IDLE);
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign ar_hit = in_window(s_axi_araddr) && (s_axi_araddr[1:0] == 2'h0);
  assign ar_idx = cnt_index(s_axi_araddr);
  assign ar_high = s_axi_araddr[2];
  assign s_axi_rvalid = (rd_state_reg == mac_stats_pkg::RD_RESP);

  // Read state sequence
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_state_reg <= mac_stats_pkg::RD_IDLE;
    end else begin
      case (rd_state_reg)
        mac_stats_pkg::RD_IDLE: begin
          if (rd_take) begin
            rd_state_reg <= mac_stats_pkg::RD_RESP;
          end
        end
        mac_stats_pkg::RD_RESP: begin
          if (s_axi_rready) begin
            rd_state_reg <= mac_stats_pkg::RD_IDLE;
          end
        end
        default: begin
          rd_state_reg <= mac_stats_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // Read data, response and low-then-high tracking
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
      last_low_reg <= 1'b0;
      last_idx_reg <= 4'h0;
      high_snap_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      last_low_reg <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      if (!ar_hit) begin
        s_axi_rresp <= `RESP_DECERR;
      end else if (!ar_high) begin
        // Low word; freeze the matching high word alongside
        s_axi_rdata <= cnt_reg[ar_idx][31:0];
        high_snap_reg <= cnt_reg[ar_idx][63:32];
        s_axi_rresp <= `RESP_OKAY;
        last_low_reg <= 1'b1;
        last_idx_reg <= ar_idx;
      end else if (last_low_reg && (last_idx_reg == ar_idx)) begin
        s_axi_rdata <= high_snap_reg;
        s_axi_rresp <= `RESP_OKAY;
      end else begin
        s_axi_rresp <= `RESP_SLVERR;
      end
    end else if (wr_take) begin
      // Any write breaks a low-then-high pair
      last_low_reg <= 1'b0;
    end
  end

endmodule

/* File: tb/axil_master.sv */
// ----------------------------------------------------------------------
// Management master model, one transfer at a time
// ----------------------------------------------------------------------
module axil_master (
  input  wire logic        i_core_clk,
  output logic      [31:0] s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic      [31:0] s_axi_wdata,
  output logic             s_axi_wvalid,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic      [31:0] s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
  end
  // Read; rready held off st cycles to make the answer wait
  task automatic rd(input logic [31:0] a, input int st,
                    output logic [31:0] d, output logic [1:0] r);
    @(negedge i_core_clk);
    s_axi_araddr = a;
    s_axi_arvalid = 1'b1;
    do @(posedge i_core_clk); while (!s_axi_arready);
    @(negedge i_core_clk);
    s_axi_arvalid = 1'b0;
    s_axi_araddr = ~a;
    repeat (st) @(negedge i_core_clk);
    s_axi_rready = 1'b1;
    do @(posedge i_core_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(negedge i_core_clk);
    s_axi_rready = 1'b0;
  endtask
  // Write; address and data travel together
  task automatic wr(input logic [31:0] a, output logic [1:0] r);
    @(negedge i_core_clk);
    s_axi_awaddr = a;
    s_axi_wdata = ~a;
    {s_axi_awvalid, s_axi_wvalid} = 2'h3;
    do @(posedge i_core_clk); while (!s_axi_awready);
    @(negedge i_core_clk);
    {s_axi_awvalid, s_axi_wvalid} = 2'h0;
    s_axi_awaddr = ~a;
    s_axi_wdata = a;
    s_axi_bready = 1'b1;
    do @(posedge i_core_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(negedge i_core_clk);
    s_axi_bready = 1'b0;
  endtask
endmodule

/* File: tb/mac_stats_checker.sv */
module mac_stats_checker (
  input wire logic        i_core_clk,
  input wire logic        i_arst_n,
  input wire logic [25:0] i_tx_flags,
  input wire logic        i_tx_flags_valid,
  input wire logic [29:0] i_rx_flags,
  input wire logic        i_rx_flags_valid,
  input wire logic [25:0] o_tx_statistics_vector,
  input wire logic        o_tx_statistics_valid,
  input wire logic [29:0] o_rx_statistics_vector,
  input wire logic        o_rx_statistics_valid,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  logic [31:0] last_addr_reg; // Address of last taken read
  logic last_rd_reg; // Last taken transaction was a read
  wire logic rd_take = s_axi_arvalid && s_axi_arready;
  wire logic wr_take = s_axi_awvalid && s_axi_wvalid && s_axi_awready
    && !s_axi_bvalid && !rd_take;
  wire logic [31:0] a = s_axi_araddr;
  wire logic hi = a[2:0] == 3'h4 && a >= 32'h204 && a <= 32'h25C;
  wire logic mapped = a[1:0] == 2'h0 && a >= 32'h200 && a <= 32'h25C;
  wire logic paired = last_rd_reg && last_addr_reg == a - 32'h4;
  wire logic wr_win = s_axi_awaddr >= 32'h200 && s_axi_awaddr <= 32'h25C;
  // Track the previous taken transaction
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      last_rd_reg <= 1'b0;
      last_addr_reg <= 32'h0;
    end else if (rd_take) begin
      last_rd_reg <= 1'b1;
      last_addr_reg <= a;
    end else if (wr_take) begin
      last_rd_reg <= 1'b0;
    end
  end
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  rd_single_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  wr_refuse_a: assert property (wr_take && wr_win |=>
    s_axi_bvalid && s_axi_bresp == 2'h2)
    else $error("counter write not refused");
  hi_refuse_a: assert property (rd_take && hi && !paired |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unpaired high read answered");
  hi_allow_a: assert property (rd_take && hi && paired |=>
    s_axi_rresp == 2'h0)
    else $error("paired high read refused");
  rd_unmapped_a: assert property (rd_take && !mapped |=>
    s_axi_rresp == 2'h3)
    else $error("unmapped read not decerr");
  rx_copy_a: assert property (i_rx_flags_valid |=>
    o_rx_statistics_valid && o_rx_statistics_vector == $past(i_rx_flags))
    else $error("rx vector not passed out");
  tx_copy_a: assert property (i_tx_flags_valid |=>
    o_tx_statistics_valid && o_tx_statistics_vector == $past(i_tx_flags))
    else $error("tx vector not passed out");
  rx_quiet_a: assert property (!i_rx_flags_valid |=>
    !o_rx_statistics_valid)
    else $error("rx strobe without input");
  tx_quiet_a: assert property (!i_tx_flags_valid |=>
    !o_tx_statistics_valid)
    else $error("tx strobe without input");
  wr_accept_a: assert property (s_axi_wready == s_axi_awready &&
    s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
    && !rd_take))
    else $error("write channels not accepted together");
endmodule

bind mac_frame_statistics_counters mac_stats_checker i_mac_stats_checker (
  .i_core_clk, .i_arst_n, .i_tx_flags, .i_tx_flags_valid, .i_rx_flags,
  .i_rx_flags_valid, .o_tx_statistics_vector, .o_tx_statistics_valid,
  .o_rx_statistics_vector, .o_rx_statistics_valid, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

/* File: tb/mac_frame_statistics_counters_tb.sv */
module mac_frame_statistics_counters_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_core_clk, i_arst_n, i_reconfig, i_tx_flags_valid, i_rx_flags_valid;
  mac_stats_pkg::tx_flags_s i_tx_flags;
  mac_stats_pkg::rx_flags_s i_rx_flags;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [63:0] exp_cnt [12]; // Expected counter values
  int err_count, check_count;
  mac_frame_statistics_counters i_mac_frame_statistics_counters (
    .i_core_clk, .i_arst_n, .i_reconfig, .i_tx_flags, .i_tx_flags_valid,
    .i_rx_flags, .i_rx_flags_valid, .o_tx_statistics_vector(),
    .o_tx_statistics_valid(), .o_rx_statistics_vector(),
    .o_rx_statistics_valid(), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  axil_master i_axil_master (
    .i_core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // 10 MHz clock
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Read one counter low then high, compare both halves
  task automatic rdc(input int i, input logic [63:0] want);
    logic [31:0] a;
    a = 32'h200 + 32'(i * 8);
    i_axil_master.rd(a, 0, d, r);
    chk(d, want[31:0]);
    chk(32'(r), 32'h0);
    i_axil_master.rd(a + 32'h4, 2, d, r);
    chk(d, want[63:32]);
    chk(32'(r), 32'h0);
  endtask
  // Back-to-back frames over every bin edge, then all counters
  task automatic t_bins;
    logic [16:0] tab [16] = '{{14'h03F, 3'h1}, {14'h03F, 3'h2},
      {14'h040, 3'h1}, {14'h041, 3'h1}, {14'h07F, 3'h1}, {14'h080, 3'h1},
      {14'h0FF, 3'h1}, {14'h100, 3'h1}, {14'h1FF, 3'h1}, {14'h200, 3'h1},
      {14'h3FF, 3'h1}, {14'h400, 3'h1}, {14'h5EE, 3'h1}, {14'h5EF, 3'h1},
      {14'h064, 3'h5}, {14'h0C8, 3'h2}};
    exp_cnt = '{64'h0, 64'h0, 64'h1, 64'h1, 64'h1, 64'h2, 64'h2, 64'h2,
      64'h2, 64'h2, 64'h1, 64'h1};
    i_reconfig = 1'b1;
    @(negedge i_core_clk);
    i_reconfig = 1'b0;
    for (int k = 0; k < 16; k++) begin
      i_rx_flags = {13'h0, tab[k]};
      i_rx_flags_valid = 1'b1;
      i_tx_flags = {11'h0, tab[k][16:3], k < 3 ? k[0] ^ 1'b1 : 1'b0};
      i_tx_flags_valid = k < 3;
      exp_cnt[0] += 64'(tab[k][16:3]);
      if (k < 3) exp_cnt[1] += 64'(tab[k][16:3]);
      @(negedge i_core_clk);
    end
    {i_rx_flags_valid, i_tx_flags_valid} = 2'h0;
    i_rx_flags = ~i_rx_flags;
    i_tx_flags = ~i_tx_flags;
    repeat (3) @(negedge i_core_clk);
    for (int i = 0; i < 12; i++) rdc(i, exp_cnt[i]);
    $display("t_bins done");
  endtask
  // Pairing, refused writes, unmapped reads, reset keeps counts
  task automatic t_pair;
    i_axil_master.rd(32'h20C, 0, d, r);
    chk(32'(r), 32'h2);
    chk(d, 32'h0);
    i_axil_master.rd(32'h208, 0, d, r);
    i_axil_master.rd(32'h214, 0, d, r);
    chk(32'(r), 32'h2);
    i_axil_master.rd(32'h200, 0, d, r);
    i_axil_master.wr(32'h200, r);
    chk(32'(r), 32'h2);
    i_axil_master.rd(32'h204, 0, d, r);
    chk(32'(r), 32'h2);
    i_axil_master.wr(32'h100, r);
    chk(32'(r), 32'h3);
    i_axil_master.rd(32'h300, 0, d, r);
    chk(32'(r), 32'h3);
    i_axil_master.rd(32'h201, 0, d, r);
    chk(32'(r), 32'h3);
    i_arst_n = 1'b0;
    repeat (2) @(negedge i_core_clk);
    i_arst_n = 1'b1;
    rdc(0, exp_cnt[0]);
    $display("t_pair done");
  endtask
  initial begin
    {i_arst_n, i_reconfig, i_tx_flags_valid, i_rx_flags_valid} = 4'h0;
    i_tx_flags = '0;
    i_rx_flags = '0;
    repeat (3) @(negedge i_core_clk);
    i_arst_n = 1'b1;
    t_bins;
    t_pair;
    end_of_test;
  end
  // Watchdog, far beyond the roughly 156 cycles the tests need
  initial begin
    #500000;
    err_count++;
    end_of_test;
  end
endmodule
